// file: design/hps_cfg.svh
// constants and reset values for the host port and status pin block
`ifndef HPS_CFG_SVH
`define HPS_CFG_SVH

`define HPS_SYN_W 7
`define HPS_SYN_SEL 0
`define HPS_SYN_SCLK 1
`define HPS_SYN_CSN 2
`define HPS_SYN_SDIO 3
`define HPS_SYN_AHI 4
`define HPS_SYN_ODIS 5
`define HPS_SYN_RST 6
`define HPS_SYN_RST_VAL 7'h00

`define HPS_STAT_W 5
`define HPS_STAT_UNLOCK 0
`define HPS_STAT_REF0 1
`define HPS_STAT_XTAL 4
`define HPS_STAT_RST_VAL 5'h01

`define HPS_SPI3_RST_VAL 1'b0
`define HPS_ADDR_RST_VAL 2'h0

`endif

// file: design/hps_pkg.sv
// types shared by the host port and status pin block
`include "hps_cfg.svh"
package hps_pkg;

  typedef enum logic [1:0] {
    HPS_I2C = 2'b00,
    HPS_SPI3 = 2'b01,
    HPS_SPI4 = 2'b11
  } hps_mode_t;

  typedef struct packed {
    logic [`HPS_SYN_W-1:0] sync1;
    logic [`HPS_SYN_W-1:0] sync2;
    logic sclk_d;
    hps_mode_t mode;
    logic spi3;
    logic [1:0] addr;
    logic rx_bit;
    logic rx_stb;
    logic tx_bit;
    logic tx_drv;
    logic [`HPS_STAT_W-1:0] stat;
    logic irq;
    logic clk_en;
  } hps_state_t;

  localparam hps_state_t HPS_ST_RST = '{
    sync1: `HPS_SYN_RST_VAL,
    sync2: `HPS_SYN_RST_VAL,
    sclk_d: 1'b0,
    mode: HPS_I2C,
    spi3: `HPS_SPI3_RST_VAL,
    addr: `HPS_ADDR_RST_VAL,
    rx_bit: 1'b0,
    rx_stb: 1'b0,
    tx_bit: 1'b0,
    tx_drv: 1'b0,
    stat: `HPS_STAT_RST_VAL,
    irq: 1'b0,
    clk_en: 1'b0
  };

endpackage

// file: design/hps_top.sv
// pin level host port mux, reset, output enable and status pins
`timescale 1ns/100ps
`default_nettype none
`include "hps_cfg.svh"
module hps_top (
  input wire logic mclk,
  input wire logic rst_n,
  // pins from the host
  input wire logic i2c_select,
  input wire logic sclk,
  input wire logic addr_lo_or_select_n,
  input wire logic sdio_i,
  output logic sdio_o,
  output logic sdio_oe,
  input wire logic addr_hi_or_spi_out_i,
  output logic addr_hi_or_spi_out_o,
  output logic addr_hi_or_spi_out_oe,
  input wire logic device_reset_n,
  input wire logic outputs_disable,
  // core side, same clock
  input wire logic cfg_wr,
  input wire logic cfg_spi_3wire,
  input wire logic tx_en,
  input wire logic tx_data,
  output logic rx_bit,
  output logic rx_stb,
  output logic host_is_i2c,
  output logic [1:0] i2c_addr_pins,
  output logic core_reset,
  input wire logic pll_locked,
  input wire logic [2:0] ref_lost,
  input wire logic xtal_lost,
  input wire logic irq_clear,
  // status and clock control pins
  output logic status_change_irq_n,
  output logic pll_locked_flag,
  output logic ref0_missing_n,
  output logic ref1_missing_n,
  output logic ref2_missing_n,
  output logic xtal_missing_n,
  output logic clk_out_en
);

  hps_pkg::hps_state_t st_r;
  hps_pkg::hps_state_t st_nxt;
  logic dev_rst;
  logic sclk_rise;
  logic sclk_fall;
  logic cs_act;
  logic [`HPS_STAT_W-1:0] stat_in;
  logic stat_chg;

  assign dev_rst = ~st_r.sync2[`HPS_SYN_RST];
  assign sclk_rise = st_r.sync2[`HPS_SYN_SCLK] & ~st_r.sclk_d;
  assign sclk_fall = ~st_r.sync2[`HPS_SYN_SCLK] & st_r.sclk_d;
  // select pin is an active-low chip select only in SPI modes
  assign cs_act = (st_r.mode != hps_pkg::HPS_I2C) & ~st_r.sync2[`HPS_SYN_CSN];
  assign stat_in = {xtal_lost, ref_lost, ~pll_locked};
  assign stat_chg = stat_in != st_r.stat;

  always_comb begin
    st_nxt = st_r;
    // every pin passes two flops before use
    st_nxt.sync1 = {device_reset_n, outputs_disable, addr_hi_or_spi_out_i, sdio_i,
                    addr_lo_or_select_n, sclk, i2c_select};
    st_nxt.sync2 = st_r.sync1;
    st_nxt.sclk_d = st_r.sync2[`HPS_SYN_SCLK];
    if (st_r.sync2[`HPS_SYN_SEL]) begin
      st_nxt.mode = hps_pkg::HPS_I2C;
    end else if (st_r.spi3) begin
      st_nxt.mode = hps_pkg::HPS_SPI3;
    end else begin
      st_nxt.mode = hps_pkg::HPS_SPI4;
    end
    if (cfg_wr) begin
      st_nxt.spi3 = cfg_spi_3wire;
    end
    if (st_r.mode == hps_pkg::HPS_I2C) begin
      // both shared pins are address straps in I2C mode
      st_nxt.addr = {st_r.sync2[`HPS_SYN_AHI], st_r.sync2[`HPS_SYN_CSN]};
    end
    st_nxt.rx_stb = 1'b0;
    if (sclk_rise && (st_r.mode == hps_pkg::HPS_I2C || cs_act)) begin
      st_nxt.rx_bit = st_r.sync2[`HPS_SYN_SDIO];
      st_nxt.rx_stb = 1'b1;
    end
    // launch outgoing data on the falling serial clock edge
    if (sclk_fall) begin
      st_nxt.tx_bit = tx_data;
      st_nxt.tx_drv = tx_en;
    end
    if (st_r.mode != hps_pkg::HPS_I2C && !cs_act) begin
      st_nxt.tx_drv = 1'b0;
    end
    st_nxt.stat = stat_in;
    // sticky: a new change wins over a clear in the same cycle
    if (stat_chg) begin
      st_nxt.irq = 1'b1;
    end else if (irq_clear) begin
      st_nxt.irq = 1'b0;
    end
    st_nxt.clk_en = ~st_r.sync2[`HPS_SYN_ODIS];
    if (dev_rst) begin
      // reset pin: everything but the synchronisers and the serial clock delay flop goes to defaults
      st_nxt = hps_pkg::HPS_ST_RST;
      st_nxt.sync1 = {device_reset_n, outputs_disable, addr_hi_or_spi_out_i, sdio_i,
                      addr_lo_or_select_n, sclk, i2c_select};
      st_nxt.sync2 = st_r.sync1;
      // keep tracking the serial clock so leaving reset shows no false edge
      st_nxt.sclk_d = st_r.sync2[`HPS_SYN_SCLK];
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= hps_pkg::HPS_ST_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  // data pin: open drain in I2C, driven in 3-wire, input only in 4-wire
  always_comb begin
    sdio_o = 1'b0;
    sdio_oe = 1'b0;
    addr_hi_or_spi_out_o = 1'b0;
    addr_hi_or_spi_out_oe = 1'b0;
    unique case (st_r.mode)
      hps_pkg::HPS_I2C: begin
        sdio_oe = st_r.tx_drv & ~st_r.tx_bit;
      end
      hps_pkg::HPS_SPI3: begin
        sdio_o = st_r.tx_bit;
        sdio_oe = st_r.tx_drv;
      end
      hps_pkg::HPS_SPI4: begin
        addr_hi_or_spi_out_o = st_r.tx_bit;
        addr_hi_or_spi_out_oe = st_r.tx_drv;
      end
      default: begin
        sdio_oe = 1'b0;
      end
    endcase
  end

  assign rx_bit = st_r.rx_bit;
  assign rx_stb = st_r.rx_stb;
  assign host_is_i2c = st_r.mode == hps_pkg::HPS_I2C;
  assign i2c_addr_pins = st_r.addr;
  assign core_reset = dev_rst;
  assign status_change_irq_n = ~st_r.irq;
  assign pll_locked_flag = ~st_r.stat[`HPS_STAT_UNLOCK];
  assign ref0_missing_n = ~st_r.stat[`HPS_STAT_REF0];
  assign ref1_missing_n = ~st_r.stat[`HPS_STAT_REF0+1];
  assign ref2_missing_n = ~st_r.stat[`HPS_STAT_REF0+2];
  assign xtal_missing_n = ~st_r.stat[`HPS_STAT_XTAL];
  assign clk_out_en = st_r.clk_en;

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);

  property p_mode_i2c;
    st_r.sync2[`HPS_SYN_SEL] && st_r.sync2[`HPS_SYN_RST] |=> host_is_i2c;
  endproperty
  a_mode_i2c: assert property (p_mode_i2c) else $error("select high did not give I2C");

  property p_mode_spi;
    !st_r.sync2[`HPS_SYN_SEL] && st_r.sync2[`HPS_SYN_RST] |=> !host_is_i2c;
  endproperty
  a_mode_spi: assert property (p_mode_spi) else $error("select low did not give SPI");

  property p_spi4_in_only;
    st_r.mode == hps_pkg::HPS_SPI4 |-> !sdio_oe;
  endproperty
  a_spi4_in_only: assert property (p_spi4_in_only) else $error("data pin driven in 4-wire");

  property p_i2c_open_drain;
    host_is_i2c && sdio_oe |-> !sdio_o && !addr_hi_or_spi_out_oe;
  endproperty
  a_i2c_open_drain: assert property (p_i2c_open_drain) else $error("I2C pin misdriven");

  property p_cs_idle;
    !host_is_i2c && st_r.sync2[`HPS_SYN_CSN] |=> !sdio_oe && !addr_hi_or_spi_out_oe;
  endproperty
  a_cs_idle: assert property (p_cs_idle) else $error("pin driven while deselected");

  property p_irq_on_change;
    !dev_rst && stat_chg |=> !status_change_irq_n;
  endproperty
  a_irq_on_change: assert property (p_irq_on_change) else $error("no interrupt on change");

  property p_reset_defaults;
    dev_rst |=> !st_r.spi3 && status_change_irq_n && !clk_out_en;
  endproperty
  a_reset_defaults: assert property (p_reset_defaults) else $error("reset left state");

  property p_clk_off_disable;
    st_r.sync2[`HPS_SYN_ODIS] |=> !clk_out_en;
  endproperty
  a_clk_off_disable: assert property (p_clk_off_disable) else $error("clocks on while disabled");

  property p_clk_on_enable;
    !st_r.sync2[`HPS_SYN_ODIS] && !dev_rst |=> clk_out_en;
  endproperty
  a_clk_on_enable: assert property (p_clk_on_enable) else $error("clocks off while enabled");

  property p_lock_follow;
    !dev_rst |=> pll_locked_flag == $past(pll_locked);
  endproperty
  a_lock_follow: assert property (p_lock_follow) else $error("lock flag wrong");

  property p_ref_follow;
    !dev_rst |=> {ref2_missing_n, ref1_missing_n, ref0_missing_n} == ~$past(ref_lost);
  endproperty
  a_ref_follow: assert property (p_ref_follow) else $error("reference loss flag wrong");

  property p_xtal_follow;
    !dev_rst |=> xtal_missing_n == !$past(xtal_lost);
  endproperty
  a_xtal_follow: assert property (p_xtal_follow) else $error("crystal loss flag wrong");

  property p_irq_clear;
    !dev_rst && irq_clear && !stat_chg |=> status_change_irq_n;
  endproperty
  a_irq_clear: assert property (p_irq_clear) else $error("interrupt not cleared");

  property p_irq_hold;
    !dev_rst && !irq_clear && !status_change_irq_n |=> !status_change_irq_n;
  endproperty
  a_irq_hold: assert property (p_irq_hold) else $error("interrupt dropped by itself");

  property p_reset_status;
    dev_rst |=> !pll_locked_flag && ref0_missing_n && ref1_missing_n && ref2_missing_n &&
      xtal_missing_n;
  endproperty
  a_reset_status: assert property (p_reset_status) else $error("status pins not reset");

  property p_reset_mode;
    dev_rst |=> host_is_i2c && i2c_addr_pins == `HPS_ADDR_RST_VAL;
  endproperty
  a_reset_mode: assert property (p_reset_mode) else $error("mode not reset");

  property p_reset_quiet;
    dev_rst |=> !rx_stb && !sdio_oe && !addr_hi_or_spi_out_oe;
  endproperty
  a_reset_quiet: assert property (p_reset_quiet) else $error("port active in reset");

  property p_rx_refused;
    !host_is_i2c && st_r.sync2[`HPS_SYN_CSN] |=> !rx_stb;
  endproperty
  a_rx_refused: assert property (p_rx_refused) else $error("bit taken while deselected");

  property p_rx_capture;
    sclk_rise && !dev_rst && (host_is_i2c || cs_act) |=>
      rx_stb && rx_bit == $past(st_r.sync2[`HPS_SYN_SDIO]);
  endproperty
  a_rx_capture: assert property (p_rx_capture) else $error("data bit not taken");

  property p_rx_pulse;
    rx_stb |=> !rx_stb;
  endproperty
  a_rx_pulse: assert property (p_rx_pulse) else $error("receive strobe too long");

  property p_tx_launch;
    sclk_fall && !dev_rst && (host_is_i2c || cs_act) |=>
      st_r.tx_bit == $past(tx_data) && st_r.tx_drv == $past(tx_en);
  endproperty
  a_tx_launch: assert property (p_tx_launch) else $error("data bit not launched");

  property p_spi3_drive;
    st_r.mode == hps_pkg::HPS_SPI3 |->
      sdio_o == st_r.tx_bit && sdio_oe == st_r.tx_drv && !addr_hi_or_spi_out_oe;
  endproperty
  a_spi3_drive: assert property (p_spi3_drive) else $error("3-wire data pin misdriven");

  property p_spi4_drive;
    st_r.mode == hps_pkg::HPS_SPI4 |->
      addr_hi_or_spi_out_o == st_r.tx_bit && addr_hi_or_spi_out_oe == st_r.tx_drv;
  endproperty
  a_spi4_drive: assert property (p_spi4_drive) else $error("4-wire output misdriven");

  property p_addr_sample;
    host_is_i2c && !dev_rst |=> i2c_addr_pins[1] == $past(st_r.sync2[`HPS_SYN_AHI]) &&
      i2c_addr_pins[0] == $past(st_r.sync2[`HPS_SYN_CSN]);
  endproperty
  a_addr_sample: assert property (p_addr_sample) else $error("address pins not taken");

  property p_addr_hold;
    !host_is_i2c && !dev_rst |=> $stable(i2c_addr_pins);
  endproperty
  a_addr_hold: assert property (p_addr_hold) else $error("address moved outside I2C");

  property p_spi3_cfg;
    cfg_wr && !dev_rst |=> st_r.spi3 == $past(cfg_spi_3wire);
  endproperty
  a_spi3_cfg: assert property (p_spi3_cfg) else $error("wire count not stored");

  property p_mode_spi3;
    !st_r.sync2[`HPS_SYN_SEL] && st_r.sync2[`HPS_SYN_RST] && st_r.spi3 |=>
      st_r.mode == hps_pkg::HPS_SPI3;
  endproperty
  a_mode_spi3: assert property (p_mode_spi3) else $error("3-wire mode not taken");

  property p_mode_spi4;
    !st_r.sync2[`HPS_SYN_SEL] && st_r.sync2[`HPS_SYN_RST] && !st_r.spi3 |=>
      st_r.mode == hps_pkg::HPS_SPI4;
  endproperty
  a_mode_spi4: assert property (p_mode_spi4) else $error("4-wire mode not taken");

endmodule
`default_nettype wire

// file: testbench/hps_host_model.sv
// host side model: serial clock, protocol pins and shared data wires
`timescale 1ns/100ps
`default_nettype none
module hps_host_model (
  input wire logic run,
  input wire logic i2c_mode,
  input wire logic sel_n,
  input wire logic dbit,
  input wire logic a1,
  input wire logic sdio_o,
  input wire logic sdio_oe,
  input wire logic ahi_o,
  input wire logic ahi_oe,
  output logic i2c_select,
  output logic sclk,
  output logic cs_pin,
  output logic sdio_i,
  output logic ahi_i
);
  // serial clock toggles only inside frames and idles low between them
  initial begin
    sclk = 1'b0;
    #37;
    forever #200 sclk = run ? ~sclk : 1'b0;
  end
  assign i2c_select = i2c_mode;
  assign cs_pin = sel_n;
  // pull-up holds the wire high in i2c when nobody pulls it down
  assign sdio_i = sdio_oe ? sdio_o : (i2c_mode | dbit);
  assign ahi_i = ahi_oe ? ahi_o : a1;
endmodule
`default_nettype wire

// file: testbench/hps_top_tb.sv
// self-checking bench for the host port and status pin block
`timescale 1ns/100ps
`default_nettype none
module hps_top_tb;
  logic mclk, rst_n, run, i2c_mode, sel_n, dbit, a1, device_reset_n, outputs_disable;
  logic cfg_wr, cfg_spi_3wire, tx_en, tx_data, pll_locked, xtal_lost, irq_clear;
  logic i2c_select, sclk, cs_pin, sdio_i, sdio_o, sdio_oe, ahi_i, ahi_o, ahi_oe;
  logic rx_bit, rx_stb, host_is_i2c, core_reset, irq_n, lock_f, clk_out_en;
  logic [2:0] ref_lost;
  logic [1:0] i2c_addr_pins;
  logic [3:0] miss_n;
  int n_mismatch = 0;
  int total_checks = 0;
  int n_stb = 0;
  int s;
  hps_host_model host_u (.run, .i2c_mode, .sel_n, .dbit, .a1, .sdio_o, .sdio_oe,
    .ahi_o, .ahi_oe, .i2c_select, .sclk, .cs_pin, .sdio_i, .ahi_i);
  hps_top dut_u (.mclk, .rst_n, .i2c_select, .sclk, .addr_lo_or_select_n(cs_pin),
    .sdio_i, .sdio_o, .sdio_oe, .addr_hi_or_spi_out_i(ahi_i),
    .addr_hi_or_spi_out_o(ahi_o), .addr_hi_or_spi_out_oe(ahi_oe), .device_reset_n,
    .outputs_disable, .cfg_wr, .cfg_spi_3wire, .tx_en, .tx_data, .rx_bit, .rx_stb,
    .host_is_i2c, .i2c_addr_pins, .core_reset, .pll_locked, .ref_lost, .xtal_lost,
    .irq_clear, .status_change_irq_n(irq_n), .pll_locked_flag(lock_f),
    .ref0_missing_n(miss_n[0]), .ref1_missing_n(miss_n[1]), .ref2_missing_n(miss_n[2]),
    .xtal_missing_n(miss_n[3]), .clk_out_en);
  always #25 mclk = ~mclk;
  always @(posedge mclk) n_stb <= n_stb + int'(rx_stb === 1'b1);
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task automatic frame;
    @(posedge mclk) run <= 1'b1;
    repeat (32) @(posedge mclk);
    run <= 1'b0;
    cyc(6);
  endtask
  task automatic clr;
    @(posedge mclk) irq_clear <= 1'b1;
    @(posedge mclk) irq_clear <= 1'b0;
    cyc(1);
    chk(irq_n, 8'h01);
  endtask
  task automatic t_reset;
    cyc(1);
    chk({irq_n, lock_f, clk_out_en, host_is_i2c, miss_n}, 8'h9f);
    cyc(6);
    chk({core_reset, clk_out_en}, 8'h01);
    @(posedge mclk) device_reset_n <= 1'b0;
    cyc(4);
    chk({core_reset, clk_out_en}, 8'h02);
    @(posedge mclk) device_reset_n <= 1'b1;
    cyc(4);
    chk(clk_out_en, 8'h01);
    $display("done reset");
  endtask
  task automatic t_oe;
    @(posedge mclk) outputs_disable <= 1'b1;
    cyc(4);
    chk(clk_out_en, 8'h00);
    @(posedge mclk) outputs_disable <= 1'b0;
    cyc(4);
    chk(clk_out_en, 8'h01);
    $display("done output enable");
  endtask
  task automatic t_status;
    clr();
    @(posedge mclk) pll_locked <= 1'b1;
    cyc(2);
    chk({lock_f, irq_n}, 8'h02);
    clr();
    for (int i = 0; i < 4; i++) begin
      @(posedge mclk) {xtal_lost, ref_lost} <= 4'h1 << i;
      cyc(2);
      chk({irq_n, miss_n}, 8'(4'hf ^ (4'h1 << i)));
      @(posedge mclk) {xtal_lost, ref_lost} <= 4'h0;
      cyc(2);
      clr();
    end
    @(posedge mclk) pll_locked <= 1'b0;
    cyc(2);
    chk({lock_f, irq_n}, 8'h00);
    clr();
    @(posedge mclk) {pll_locked, irq_clear} <= 2'h3;
    @(posedge mclk) irq_clear <= 1'b0;
    cyc(1);
    chk({lock_f, irq_n}, 8'h02);
    $display("done status");
  endtask
  task automatic t_i2c;
    @(posedge mclk) {a1, sel_n} <= 2'h2;
    cyc(4);
    chk({host_is_i2c, ahi_oe, i2c_addr_pins}, 8'h0a);
    @(posedge mclk) {a1, sel_n} <= 2'h1;
    cyc(4);
    chk(i2c_addr_pins, 8'h01);
    s = n_stb;
    frame();
    chk(8'(n_stb - s), 8'h04);
    chk({rx_bit, sdio_oe, ahi_oe}, 8'h04);
    $display("done i2c address");
  endtask
  task automatic t_spi;
    @(posedge mclk) {i2c_mode, sel_n, dbit, tx_en, tx_data} <= 5'h07;
    cyc(4);
    chk(host_is_i2c, 8'h00);
    s = n_stb;
    frame();
    chk(8'(n_stb - s), 8'h04);
    chk({rx_bit, ahi_oe, ahi_o, sdio_oe}, 8'h0e);
    @(posedge mclk) {sel_n, dbit} <= 2'h2;
    cyc(5);
    chk(ahi_oe, 8'h00);
    s = n_stb;
    frame();
    chk(8'(n_stb - s), 8'h00);
    @(posedge mclk) {cfg_wr, cfg_spi_3wire, sel_n} <= 3'h6;
    @(posedge mclk) cfg_wr <= 1'b0;
    frame();
    chk({ahi_oe, sdio_oe, sdio_o}, 8'h03);
    @(posedge mclk) sel_n <= 1'b1;
    cyc(5);
    chk(sdio_oe, 8'h00);
    $display("done spi");
  endtask
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  initial begin
    #2000000;
    n_mismatch++;
    print_verdict();
  end
  initial begin
    {mclk, rst_n} = '0;
    {run, dbit, a1, outputs_disable, cfg_wr, cfg_spi_3wire, tx_en, tx_data} = '0;
    {pll_locked, xtal_lost, irq_clear, ref_lost} = '0;
    {i2c_mode, sel_n, device_reset_n} = '1;
    repeat (2) @(posedge mclk);
    rst_n <= 1'b1;
    t_reset();
    t_oe();
    t_status();
    t_i2c();
    t_spi();
    print_verdict();
  end
endmodule
`default_nettype wire
